/* File: fsr_flash_model.sv */
/*
 behavioural flash device: status register, status and array read modes.
 assumes host pins from fsr_top; status events come from the bench.
*/
`timescale 1ns/1ns
module fsr_flash_model (
  // pins
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rst_n,
  input  wire logic [20:0] addr,
  input  wire logic [15:0] dq_wr,
  output logic [15:0]      dq_rd,
  // status events
  input  wire logic        upd,
  input  wire logic [7:0]  set_bits,
  input  wire logic [7:0]  clr_bits
);
  import fsr_pkg::*;
  logic [7:0]  sr = 8'h00;
  logic [15:0] q = 16'h0;
  logic        stat = 1'b0;
  logic        arm = 1'b0;
  always @(negedge rst_n or posedge upd) begin
    if (!rst_n) begin
      sr = 8'h00;
      stat = 1'b0;
    end else begin
      sr = (sr | set_bits) & ~(clr_bits & 8'hc4);
    end
  end
  always @(negedge we_n or negedge cs_n)
    if (!we_n && !cs_n && oe_n) arm = 1'b1;
  always @(posedge we_n or posedge cs_n) begin
    if (arm && rst_n) begin
      arm = 1'b0;
      if (dq_wr[7:0] == OP_CLEAR) sr = sr & ~SEQ_ERR;
      else stat = dq_wr[7:0] == OP_RSTAT;
    end
  end
  always @(negedge oe_n or negedge cs_n)
    if (!oe_n && !cs_n) q = stat ? {8'h00, sr} : addr[15:0] ^ 16'h5a3c;
  assign dq_rd = (!oe_n && !cs_n && rst_n) ? q : ~q;
endmodule : fsr_flash_model

/* File: fsr_pin_if.sv */
/*
 interface between the sequencer and the pin driver.
 assumes one ref_clk domain.
*/
`timescale 1ns/1ns
interface fsr_pin_if;
  logic        req;
  logic        wr;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport drv (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fsr_pin_if

/* File: fsr_pins.sv */
/*
 pin driver: one write or read cycle on the flash bus per request.
 assumes dq inputs asynchronous; two flops before use.
*/
`timescale 1ns/1ns
module fsr_pins (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // sequencer side
  fsr_pin_if.drv           pif,
  // flash pins
  output logic             chip_select_n,
  output logic             output_drive_n,
  output logic             write_strobe_n,
  output logic [20:0]      flash_addr,
  output logic [15:0]      dq_out,
  output logic             dq_oe,
  input  wire logic [15:0] dq_in
);
  import fsr_pkg::*;
  typedef enum logic [3:0] {
    P_IDLE = 4'b0001, P_LOW = 4'b0010, P_HIGH = 4'b0100, P_DONE = 4'b1000
  } fsr_pst_e;
  fsr_pst_e    st_ff;
  logic [7:0]  cnt_ff;
  logic        wr_ff;
  logic [15:0] s1_ff, s2_ff, rd_ff;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= 16'h0000;
      s2_ff <= 16'h0000;
    end else begin
      s1_ff <= dq_in;
      s2_ff <= s1_ff;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff          <= P_IDLE;
      cnt_ff         <= 8'h00;
      wr_ff          <= 1'b0;
      chip_select_n  <= 1'b1;
      output_drive_n <= 1'b1;
      write_strobe_n <= 1'b1;
      flash_addr     <= 21'h000000;
      dq_out         <= 16'h0000;
      dq_oe          <= 1'b0;
      rd_ff          <= 16'h0000;
    end else begin
      case (st_ff)
        P_IDLE: begin
          if (pif.req) begin
            wr_ff          <= pif.wr;
            flash_addr     <= pif.addr;
            dq_out         <= pif.wdata;
            dq_oe          <= pif.wr;
            chip_select_n  <= 1'b0;
            // each read is a fresh falling edge, snapshot refreshed
            output_drive_n <= pif.wr;
            // strobe low with select low and drive high
            write_strobe_n <= !pif.wr;
            cnt_ff         <= pif.wr ? WP_CYC : ACC_CYC;
            st_ff          <= P_LOW;
          end
        end
        P_LOW: begin
          if (cnt_ff > 8'h01) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else begin
            if (!wr_ff) begin
              rd_ff <= s2_ff;
            end
            // rising edge latches address and data
            write_strobe_n <= 1'b1;
            output_drive_n <= 1'b1;
            chip_select_n  <= 1'b1;
            cnt_ff         <= HI_CYC;
            st_ff          <= P_HIGH;
          end
        end
        P_HIGH: begin
          dq_oe <= 1'b0;
          if (cnt_ff > 8'h01) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else begin
            st_ff <= P_DONE;
          end
        end
        P_DONE: begin
          st_ff <= P_IDLE;
        end
        default: begin
          st_ff <= P_IDLE;
        end
      endcase
    end
  end
  assign pif.done  = (st_ff == P_DONE);
  assign pif.rdata = rd_ff;
endmodule : fsr_pins

/* File: fsr_pkg.sv */
/*
 pkg for the flash status controller: register map, opcodes, bus timing, status bits.
 assumes a 250 MHz ref_clk and a 16-bit asynchronous nor bus outside.
*/
package fsr_pkg;
  // own register map (byte addresses)
  localparam logic [7:0]  CTRL_OFF    = 8'h00;
  localparam logic [7:0]  CMD_OFF     = 8'h04;
  localparam logic [7:0]  STAT_OFF    = 8'h08;
  localparam logic [7:0]  RDATA_OFF   = 8'h0c;
  localparam logic [7:0]  ADDR_OFF    = 8'h10;
  // ctrl bits
  localparam int          CTRL_GO     = 0;
  localparam int          CTRL_RST    = 1;
  // command kinds in cmd register [1:0]
  localparam logic [1:0]  KIND_RSTAT  = 2'h0;
  localparam logic [1:0]  KIND_CLEAR  = 2'h1;
  localparam logic [1:0]  KIND_ARRAY  = 2'h2;
  localparam logic [1:0]  KIND_POLL   = 2'h3;
  // opcodes, low byte only
  localparam logic [7:0]  OP_RSTAT    = 8'h70;
  localparam logic [7:0]  OP_CLEAR    = 8'h50;
  localparam logic [7:0]  OP_ARRAY    = 8'hff;
  // status bit positions
  localparam int          SB_READY    = 7;
  localparam int          SB_EHALT    = 6;
  localparam int          SB_EFAIL    = 5;
  localparam int          SB_PFAIL    = 4;
  localparam int          SB_VLOW     = 3;
  localparam int          SB_PHALT    = 2;
  localparam int          SB_LOCKED   = 1;
  localparam logic [7:0]  STAT_MASK   = 8'hfe;
  localparam logic [7:0]  SEQ_ERR     = 8'h3a;
  // pin timing, ns and cycles at 4 ns
  localparam int          CLK_NS      = 4;
  localparam int          T_WP_NS     = 50;
  localparam int          T_ACC_NS    = 80;
  localparam int          T_HI_NS     = 30;
  localparam logic [7:0]  WP_CYC      = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  ACC_CYC     = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  HI_CYC      = 8'((T_HI_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  HREAD_RESET = 8'h00;
endpackage : fsr_pkg

/* File: fsr_seq.sv */
/*
 sequencer: runs flash status commands from registers.
 assumes one bus master, whole-word single transfers, ref_clk at 250 MHz.
*/
`timescale 1ns/1ns
module fsr_seq (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // orders
  input  wire logic        go,
  input  wire logic [1:0]  kind,
  input  wire logic [20:0] addr,
  input  wire logic        dev_rst,
  // pin driver
  fsr_pin_if.seq           pif,
  // report
  output logic             busy,
  output logic [7:0]       status_ff,
  output logic [15:0]      rdata_ff,
  output logic             upper_err_ff,
  output logic             in_status_ff
);
  import fsr_pkg::*;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001, S_WCMD = 4'b0010, S_READ = 4'b0100, S_WAIT = 4'b1000
  } fsr_sst_e;
  fsr_sst_e    st_ff;
  logic [1:0]  kind_ff;
  logic        req_ff;
  logic        wr_ff;
  logic [7:0]  op_ff;
  logic [20:0] addr_ff;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] kind_op(input logic [1:0] k);
    if (k == KIND_CLEAR) begin
      return OP_CLEAR;
    end else if (k == KIND_ARRAY) begin
      return OP_ARRAY;
    end else begin
      return OP_RSTAT;
    end
  endfunction : kind_op
  ////////////////////////////////////////////////////////////////////////
  assign pif.req   = req_ff;
  assign pif.wr    = wr_ff;
  assign pif.addr  = addr_ff;
  // opcode on the low byte, upper byte zero
  assign pif.wdata = {8'h00, op_ff};
  assign busy      = (st_ff != S_IDLE);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff        <= S_IDLE;
      kind_ff      <= KIND_RSTAT;
      req_ff       <= 1'b0;
      wr_ff        <= 1'b0;
      op_ff        <= 8'h00;
      addr_ff      <= 21'h000000;
      status_ff    <= 8'h00;
      rdata_ff     <= 16'h0000;
      upper_err_ff <= 1'b0;
      in_status_ff <= 1'b0;
    end else begin
      // device reset drops it back to array reads
      if (dev_rst) begin
        in_status_ff <= 1'b0;
      end
      case (st_ff)
        S_IDLE: begin
          if (go) begin
            kind_ff <= kind;
            addr_ff <= addr;
            op_ff   <= kind_op(kind);
            req_ff  <= 1'b1;
            // poll reuses status mode, no command cycle
            wr_ff   <= !(kind == KIND_POLL && in_status_ff);
            st_ff   <= (kind == KIND_POLL && in_status_ff) ? S_READ : S_WCMD;
          end
        end
        S_WCMD: begin
          req_ff <= 1'b0;
          if (pif.done) begin
            // array data needs the read command first
            in_status_ff <= (kind_ff == KIND_RSTAT) || (kind_ff == KIND_POLL);
            if (kind_ff == KIND_CLEAR) begin
              status_ff <= 8'h00;
              st_ff     <= S_IDLE;
            end else begin
              req_ff <= 1'b1;
              wr_ff  <= 1'b0;
              st_ff  <= S_READ;
            end
          end
        end
        S_READ: begin
          req_ff <= 1'b0;
          st_ff  <= S_WAIT;
        end
        S_WAIT: begin
          if (pif.done) begin
            if (kind_ff == KIND_ARRAY) begin
              rdata_ff <= pif.rdata;
            end else begin
              // reserved bit masked out
              status_ff    <= pif.rdata[7:0] & STAT_MASK;
              upper_err_ff <= (pif.rdata[15:8] != 8'h00);
            end
            st_ff <= S_IDLE;
          end
        end
        default: begin
          st_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule : fsr_seq

/* File: fsr_top.sv */
/*
 host controller for the flash status register, ahb-lite slave for software.
 assumes single-word transfers, one master, flash dq resolved outside.
*/
`timescale 1ns/1ns
module fsr_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // flash pins
  output logic             chip_select_n,
  output logic             output_drive_n,
  output logic             write_strobe_n,
  output logic             flash_reset_n,
  output logic [20:0]      flash_addr,
  output logic [15:0]      dq_out,
  output logic             dq_oe,
  input  wire logic [15:0] dq_in
);
  import fsr_pkg::*;
  fsr_pin_if   pif ();
  logic        wr_ph_ff;
  logic [7:0]  ad_ph_ff;
  logic        go_ff;
  logic [1:0]  kind_ff;
  logic [20:0] addr_ff;
  logic        rst_ff;
  logic        busy;
  logic [7:0]  status_ff;
  logic [15:0] rdata_ff;
  logic        upper_err_ff;
  logic        in_status_ff;
  logic        seq_err;
  ////////////////////////////////////////////////////////////////////////
  // ahb address phase capture
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ph_ff <= 1'b0;
      ad_ph_ff <= 8'h00;
    end else if (hready) begin
      wr_ph_ff <= hsel && htrans[1] && hwrite;
      ad_ph_ff <= haddr[7:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      go_ff   <= 1'b0;
      kind_ff <= KIND_RSTAT;
      addr_ff <= 21'h000000;
      rst_ff  <= 1'b0;
    end else begin
      go_ff <= 1'b0;
      if (wr_ph_ff && ad_ph_ff == CTRL_OFF) begin
        go_ff  <= hwdata[CTRL_GO] && !busy;
        // drive device reset pin; device clears status then
        rst_ff <= hwdata[CTRL_RST];
      end else if (wr_ph_ff && ad_ph_ff == CMD_OFF) begin
        kind_ff <= hwdata[1:0];
      end else if (wr_ph_ff && ad_ph_ff == ADDR_OFF) begin
        addr_ff <= hwdata[20:0];
      end
    end
  end
  assign flash_reset_n = !rst_ff;
  ////////////////////////////////////////////////////////////////////////
  // status decode: errors 1,3,4,5 together
  assign seq_err = ((status_ff & SEQ_ERR) == SEQ_ERR);
  // register reads, combinational on data phase
  always_comb begin
    hrdata = 32'h00000000;
    if (ad_ph_ff == CTRL_OFF) begin
      hrdata = {30'h00000000, rst_ff, busy};
    end else if (ad_ph_ff == CMD_OFF) begin
      hrdata = {30'h00000000, kind_ff};
    end else if (ad_ph_ff == STAT_OFF) begin
      // bit 7 ready, 6 ehalt, 5..1 failure/halt/lock flags as read
      hrdata = {21'h000000, in_status_ff, upper_err_ff, seq_err, status_ff};
    end else if (ad_ph_ff == RDATA_OFF) begin
      hrdata = {16'h0000, rdata_ff};
    end else if (ad_ph_ff == ADDR_OFF) begin
      hrdata = {11'h000, addr_ff};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  fsr_seq u_seq (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .go           (go_ff),
    .kind         (kind_ff),
    .addr         (addr_ff),
    .dev_rst      (rst_ff),
    .pif          (pif.seq),
    .busy         (busy),
    .status_ff    (status_ff),
    .rdata_ff     (rdata_ff),
    .upper_err_ff (upper_err_ff),
    .in_status_ff (in_status_ff)
  );
  fsr_pins u_pins (
    .ref_clk        (ref_clk),
    .rstn           (rstn),
    .pif            (pif.drv),
    .chip_select_n  (chip_select_n),
    .output_drive_n (output_drive_n),
    .write_strobe_n (write_strobe_n),
    .flash_addr     (flash_addr),
    .dq_out         (dq_out),
    .dq_oe          (dq_oe),
    .dq_in          (dq_in)
  );
endmodule : fsr_top

/* File: fsr_top_asserts.sv */
/*
 checker for fsr_top: flash pin cycles and status word on the bus.
 assumes binding to fsr_top and one ref_clk domain.
*/
`timescale 1ns/1ns
module fsr_top_chk (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // pins
  input wire logic        chip_select_n,
  input wire logic        output_drive_n,
  input wire logic        write_strobe_n,
  input wire logic [20:0] flash_addr,
  input wire logic        dq_oe
);
  import fsr_pkg::*;
  logic st_rd_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      st_rd_ff <= 1'b0;
    else
      st_rd_ff <= hsel && hready && htrans[1] && !hwrite && haddr[7:0] == STAT_OFF;
  end
  a_write_shape: assert property (!write_strobe_n |-> !chip_select_n && output_drive_n && dq_oe)
    else $error("write cycle shape wrong");
  a_read_shape: assert property (!output_drive_n |-> !chip_select_n && write_strobe_n && !dq_oe)
    else $error("read cycle shape wrong");
  a_write_len: assert property ($fell(write_strobe_n) |->
    (!write_strobe_n)[*8] ##1 (!write_strobe_n)[*5] ##1 write_strobe_n)
    else $error("write strobe length wrong");
  a_read_len: assert property ($fell(output_drive_n) |->
    (!output_drive_n)[*8] ##1 (!output_drive_n)[*8] ##1 (!output_drive_n)[*4] ##1 output_drive_n)
    else $error("read strobe length wrong");
  a_read_toggle: assert property ($rose(output_drive_n) |-> chip_select_n[*8])
    else $error("select not toggled after read");
  a_addr_hold: assert property (!chip_select_n && !$fell(chip_select_n) |-> $stable(flash_addr))
    else $error("address moved in cycle");
  a_stat_mask: assert property (st_rd_ff |-> !hrdata[0] && hrdata[31:11] == 21'h0)
    else $error("reserved status bit seen");
  a_seq_flag: assert property (st_rd_ff |-> hrdata[8] == (hrdata[5:3] == 3'h7 && hrdata[1]))
    else $error("sequence error flag wrong");
endmodule : fsr_top_chk

bind fsr_top fsr_top_chk i_chk (.*);

/* File: test_flash_status_register_logic.sv */
/*
 testbench for fsr_top with a behavioural flash device.
 assumes 250 MHz ref_clk and one bus master in the bench.
*/
`timescale 1ns/1ns
module test_flash_status_register_logic;
  import fsr_pkg::*;
  logic        ref_clk, rstn, hsel, hwrite, hready, hreadyout, hresp, upd;
  logic        cs_n, oe_n, we_n, frst_n, dq_oe;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [20:0] faddr, a;
  logic [15:0] dq_out, dq_in, dq_rd;
  logic [7:0]  set_b, clr_b, sr_m;
  int          mismatches, cmp_count, cyc;

  fsr_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .chip_select_n(cs_n), .output_drive_n(oe_n),
    .write_strobe_n(we_n), .flash_reset_n(frst_n), .flash_addr(faddr), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in));
  fsr_flash_model i_dev (.cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .rst_n(frst_n), .addr(faddr),
    .dq_wr(dq_out), .dq_rd(dq_rd), .upd(upd), .set_bits(set_b), .clr_bits(clr_b));
  assign dq_in = dq_oe ? dq_out : dq_rd;
  assign hready = hreadyout;

  ////////////////////////////////////////////////////////////////////////////////
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    logic rdy;
    logic rsp;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    // values settled before the edge that samples them
    do begin
      @(negedge ref_clk);
      rdy = hready;
      @(posedge ref_clk);
    end while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge ref_clk);
      rdy = hready;
      q = hrdata;
      rsp = hresp;
      @(posedge ref_clk);
    end while (rdy !== 1'b1);
    chk("hresp", 32'h0, {31'h0, rsp});
  endtask : ahb

  function automatic logic [31:0] st_exp(input logic [7:0] s);
    return {21'h0, 1'b1, 1'b0, (s & SEQ_ERR) == SEQ_ERR, s & STAT_MASK};
  endfunction : st_exp

  task automatic run(input logic [1:0] k);
    int i;
    ahb(1'b1, CMD_OFF, {30'h0, k});
    ahb(1'b1, CTRL_OFF, 32'h1);
    for (i = 0; i < 60 && cs_n !== 1'b0; i++) @(posedge ref_clk);
    for (i = 0; i < 100; i++) begin
      ahb(1'b0, CTRL_OFF, 32'h0);
      if (q[0] === 1'b0) break;
    end
    chk("busy", 32'h0, q & 32'h1);
  endtask : run

  task automatic stat_chk(input logic [1:0] k);
    run(k);
    ahb(1'b0, STAT_OFF, 32'h0);
    chk("status", st_exp(sr_m), q);
  endtask : stat_chk

  task automatic ev(input logic [7:0] s, input logic [7:0] c);
    set_b <= s;
    clr_b <= c;
    @(posedge ref_clk);
    upd <= 1'b1;
    @(posedge ref_clk);
    upd <= 1'b0;
    sr_m = (sr_m | s) & ~(c & 8'hc4);
  endtask : ev

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {ref_clk, rstn, hsel, hwrite, upd, htrans, haddr, hwdata} = '0;
    {set_b, clr_b, sr_m, mismatches, cmp_count, cyc} = '0;
    hsize = 3'h2;
    q = $urandom(2835);
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    ahb(1'b0, STAT_OFF, 32'h0);
    chk("stat_reset", 32'h0, q);
    ahb(1'b1, 8'h24, 32'hffffffff);
    ahb(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'h0, q);
    for (int n = 0; n < 8; n++) begin
      ev(n == 3 ? SEQ_ERR : 8'($urandom) & STAT_MASK, 8'($urandom));
      stat_chk(n[0] ? KIND_POLL : KIND_RSTAT);
    end
    run(KIND_CLEAR);
    sr_m = sr_m & ~SEQ_ERR;
    stat_chk(KIND_POLL);
    for (int n = 0; n < 3; n++) begin
      a = 21'($urandom);
      ahb(1'b1, ADDR_OFF, {11'h0, a});
      run(KIND_ARRAY);
      ahb(1'b0, RDATA_OFF, 32'h0);
      chk("array", {16'h0, a[15:0] ^ 16'h5a3c}, q);
      ahb(1'b0, STAT_OFF, 32'h0);
      chk("mode", 32'h0, q & 32'h400);
    end
    stat_chk(KIND_POLL);
    ahb(1'b1, CTRL_OFF, 32'h2);
    ahb(1'b0, CTRL_OFF, 32'h0);
    chk("reset_bit", 32'h2, q & 32'h2);
    chk("reset_pin", 32'h0, {31'h0, frst_n});
    ahb(1'b1, CTRL_OFF, 32'h0);
    sr_m = 8'h00;
    stat_chk(KIND_POLL);
    summarize();
  end
endmodule : test_flash_status_register_logic
